// ---- common/uai_pkg.sv ----
// Summary of operation
// RULE_01: Seven-bit device address, cleared by hardware, software and bus reset.
// RULE_02: Only tokens whose address equals the stored address are carried out.
// RULE_03: CPU writes to the address take effect only in software control mode.
// RULE_04: Software control select bit: 0 normal, 1 software control; resets 0.
// RULE_05: Isochronous overrun or underrun sets bit 15 at token receive end.
// RULE_06: Isochronous OUT data not stored, buffer unread by CPU, is overrun.
// RULE_07: Isochronous IN data not sent, buffer unwritten by CPU, is underrun.
// RULE_08: CRC or bit stuffing error on isochronous receive also sets overrun.
// RULE_09: Isochronous OUT CRC or stuffing error sets bit 14 at transaction end.
// RULE_10: Setting overrun or receive error raises the buffer not ready interrupt.
// RULE_11: Both flags clear on a written 0, keep on a written 1; reset to 0.
// RULE_12: Eleven-bit read-only frame number, reset to zero.
// RULE_13: With timing bit 11 clear the frame number updates on each SOF.
// RULE_14: With timing bit set it updates at each isochronous transaction end.
// RULE_15: Reserved bits read zero and ignore writes.
package uai_pkg;
   // =====================================================
   // Register offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_ADDR     = 8'h08;
   localparam logic [7:0] OFS_ISO      = 8'h0a;
   localparam logic [7:0] OFS_INT_STAT = 8'h0c;
   localparam logic [7:0] OFS_INT_MASK = 8'h0e;
   // =====================================================
   // Field positions
   localparam int SCS_BIT   = 1;
   localparam int OVR_BIT   = 15;
   localparam int RXE_BIT   = 14;
   localparam int TIMING_BIT = 11;
   localparam int FRAME_MSB = 10;
   localparam int ADDR_MSB  = 6;
   localparam int INT_NRDY  = 0;
   localparam int INT_SOF   = 1;
   localparam int INT_W     = 2;
   // =====================================================
   // Reset values
   localparam logic [6:0]  ADDR_RST  = 7'h00;
   localparam logic [10:0] FRAME_RST = 11'h000;
   localparam logic [15:0] DATA_ZERO = 16'h0000;
   // =====================================================
   // Carriers
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } uai_bus_t;
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
      logic [3:0] endp;
   } uai_token_t;
   typedef struct packed {
      logic tok_end;
      logic trans_end;
      logic iso;
      logic dir_out;
      logic buf_nrdy;
      logic crc_err;
      logic stuff_err;
   } uai_iso_t;
   typedef struct packed {
      logic        valid;
      logic [10:0] frame;
   } uai_sof_t;
endpackage

// ---- logic/uai_usb_address_iso_status.sv ----
module uai_usb_address_iso_status (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              sw_reset,
   input  wire logic              bus_reset,
   input  wire uai_pkg::uai_bus_t bus,
   output logic [15:0]            rdata,
   input  wire logic              set_addr_valid,
   input  wire logic [6:0]        set_addr_value,
   input  wire uai_pkg::uai_token_t tok,
   input  wire uai_pkg::uai_iso_t   ev,
   input  wire uai_pkg::uai_sof_t   sof,
   output logic [6:0]             dev_addr,
   output logic                   token_hit,
   output logic [3:0]             token_endp,
   output logic                   nrdy_pulse,
   output logic                   irq
);
   // =====================================================
   // Helpers
   function automatic logic wr_at(input logic [7:0] ofs);
      wr_at = bus.wr && (bus.addr == ofs);
   endfunction

   function automatic logic rx_bad(input uai_pkg::uai_iso_t e);
      rx_bad = e.crc_err || e.stuff_err;
   endfunction

   logic                    scs;
   logic                    frame_capture_timing_select;
   logic                    ovr_flag;
   logic                    rxe_flag;
   logic [10:0]             frame_num;
   logic [10:0]             sof_last;
   logic [uai_pkg::INT_W-1:0] int_stat;
   logic [uai_pkg::INT_W-1:0] int_mask;
   logic                    soft_rst;
   logic                    overrun_out;
   logic                    underrun_in;
   logic                    rx_err_end;
   logic                    ovr_set;
   logic                    rxe_set;
   logic                    ovr_clr;
   logic                    rxe_clr;
   logic [uai_pkg::INT_W-1:0] int_set;
   logic [uai_pkg::INT_W-1:0] next_int_stat;
   logic                    next_ovr;
   logic                    next_rxe;

   // =====================================================
   // Event decode
   assign soft_rst    = rst || sw_reset;
   assign overrun_out = ev.tok_end && ev.iso && ev.dir_out && ev.buf_nrdy; // RULE_06
   assign underrun_in = ev.tok_end && ev.iso && !ev.dir_out && ev.buf_nrdy; // RULE_07
   assign rx_err_end  = ev.trans_end && ev.iso && ev.dir_out && rx_bad(ev);
   assign ovr_set     = overrun_out || underrun_in || rx_err_end; // RULE_05 RULE_08
   assign rxe_set     = rx_err_end; // RULE_09
   assign ovr_clr     = wr_at(uai_pkg::OFS_ISO) && !bus.wdata[uai_pkg::OVR_BIT]; // RULE_11
   assign rxe_clr     = wr_at(uai_pkg::OFS_ISO) && !bus.wdata[uai_pkg::RXE_BIT]; // RULE_11
   // Set beats a same-cycle clear
   assign next_ovr    = ovr_set || (ovr_flag && !ovr_clr);
   assign next_rxe    = rxe_set || (rxe_flag && !rxe_clr);

   // =====================================================
   // Software control select
   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         scs <= 1'b0; // RULE_04
      end else if (ce && wr_at(uai_pkg::OFS_CTRL)) begin
         scs <= bus.wdata[uai_pkg::SCS_BIT]; // RULE_04
      end
   end

   // =====================================================
   // Device address: hardware load in normal mode, CPU in software mode
   always_ff @(posedge clk_sys) begin
      if (soft_rst || (ce && bus_reset)) begin
         dev_addr <= uai_pkg::ADDR_RST; // RULE_01
      end else if (ce) begin
         if (scs && wr_at(uai_pkg::OFS_ADDR)) begin
            dev_addr <= bus.wdata[uai_pkg::ADDR_MSB:0]; // RULE_03
         end else if (!scs && set_addr_valid) begin
            dev_addr <= set_addr_value; // RULE_01
         end
      end
   end

   // =====================================================
   // Token address filter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         token_hit  <= 1'b0;
         token_endp <= 4'h0;
      end else if (ce) begin
         token_hit  <= tok.valid && (tok.addr == dev_addr); // RULE_02
         token_endp <= tok.endp;
      end
   end

   // =====================================================
   // Isochronous error flags
   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         ovr_flag <= 1'b0; // RULE_11
         rxe_flag <= 1'b0; // RULE_11
      end else if (ce) begin
         ovr_flag <= next_ovr; // RULE_05
         rxe_flag <= next_rxe; // RULE_09
      end
   end

   // =====================================================
   // Frame capture timing select
   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         frame_capture_timing_select <= 1'b0;
      end else if (ce && wr_at(uai_pkg::OFS_ISO)) begin
         frame_capture_timing_select <= bus.wdata[uai_pkg::TIMING_BIT];
      end
   end

   // =====================================================
   // Frame number: SOF or isochronous transaction end
   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         sof_last  <= uai_pkg::FRAME_RST;
         frame_num <= uai_pkg::FRAME_RST; // RULE_12
      end else if (ce) begin
         if (sof.valid) begin
            sof_last <= sof.frame;
         end
         if (!frame_capture_timing_select && sof.valid) begin
            frame_num <= sof.frame; // RULE_13
         end else if (frame_capture_timing_select && ev.trans_end && ev.iso) begin
            frame_num <= sof_last; // RULE_14
         end
      end
   end

   // =====================================================
   // Interrupt status, mask and output
   assign int_set[uai_pkg::INT_NRDY] = ovr_set || rxe_set; // RULE_10
   assign int_set[uai_pkg::INT_SOF]  = sof.valid;
   always_comb begin
      next_int_stat = int_stat | int_set;
      if (wr_at(uai_pkg::OFS_INT_STAT)) begin
         next_int_stat = int_set |
            (int_stat & ~bus.wdata[uai_pkg::INT_W-1:0]);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         int_stat <= '0;
         int_mask <= '0;
      end else if (ce) begin
         int_stat <= next_int_stat;
         if (wr_at(uai_pkg::OFS_INT_MASK)) begin
            int_mask <= bus.wdata[uai_pkg::INT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         irq        <= 1'b0;
         nrdy_pulse <= 1'b0;
      end else if (ce) begin
         irq        <= |(int_stat & int_mask);
         nrdy_pulse <= ovr_set || rxe_set; // RULE_10
      end
   end

   // =====================================================
   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata <= uai_pkg::DATA_ZERO;
      end else if (ce) begin
         rdata <= uai_pkg::DATA_ZERO;
         if (bus.rd) begin
            unique case (bus.addr)
               uai_pkg::OFS_CTRL: begin
                  rdata[uai_pkg::SCS_BIT] <= scs;
               end
               uai_pkg::OFS_ADDR: begin
                  rdata[uai_pkg::ADDR_MSB:0] <= dev_addr; // RULE_15
               end
               uai_pkg::OFS_ISO: begin
                  rdata[uai_pkg::OVR_BIT]        <= ovr_flag;
                  rdata[uai_pkg::RXE_BIT]        <= rxe_flag;
                  rdata[uai_pkg::TIMING_BIT]     <= frame_capture_timing_select;
                  rdata[uai_pkg::FRAME_MSB:0]    <= frame_num; // RULE_15
               end
               uai_pkg::OFS_INT_STAT: begin
                  rdata[uai_pkg::INT_W-1:0] <= int_stat;
               end
               uai_pkg::OFS_INT_MASK: begin
                  rdata[uai_pkg::INT_W-1:0] <= int_mask;
               end
               default: begin
                  rdata <= uai_pkg::DATA_ZERO;
               end
            endcase
         end
      end
   end

   // =====================================================
   // Checks
   addr_reset_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
      (ce && bus_reset) |=> (dev_addr == uai_pkg::ADDR_RST))
      else $error("address not cleared by bus reset");

   token_match_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_02
      (ce && tok.valid && (tok.addr != dev_addr)) |=> !token_hit)
      else $error("token for other address accepted");

   addr_lock_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_03
      (ce && !scs && !set_addr_valid && !bus_reset && !sw_reset)
      |=> $stable(dev_addr))
      else $error("address changed outside software mode");

   scs_reset_a: assert property (@(posedge clk_sys) // RULE_04
      sw_reset |=> !scs)
      else $error("software select not cleared");

   ovr_set_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_05
      (ce && ev.tok_end && ev.iso && ev.buf_nrdy) |=> ovr_flag)
      else $error("overrun not flagged");

   out_ovr_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_06
      (ce && overrun_out) |=> ovr_flag)
      else $error("out overrun not flagged");

   in_under_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_07
      (ce && underrun_in) |=> ovr_flag)
      else $error("in underrun not flagged");

   stuff_ovr_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_08
      (ce && ev.trans_end && ev.iso && ev.dir_out && ev.stuff_err) |=> ovr_flag)
      else $error("stuffing error not flagged as overrun");

   crc_ovr_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_09
      (ce && rx_err_end) |=> (ovr_flag && rxe_flag))
      else $error("receive error flags missing");

   nrdy_int_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_10
      (ce && (ovr_set || rxe_set)) |=> (nrdy_pulse && int_stat[uai_pkg::INT_NRDY]))
      else $error("not ready interrupt missing");

   flag_keep_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_11
      (ce && ovr_flag && !ovr_set && wr_at(uai_pkg::OFS_ISO)
       && bus.wdata[uai_pkg::OVR_BIT]) |=> ovr_flag)
      else $error("overrun lost on written one");

   flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_11
      (ce && !ovr_set && ovr_clr) |=> !ovr_flag)
      else $error("overrun not cleared by zero");

   rxe_clear_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_11
      (ce && !rxe_set && rxe_clr) |=> !rxe_flag)
      else $error("receive error not cleared by zero");

   frame_rst_a: assert property (@(posedge clk_sys) // RULE_12
      sw_reset |=> (frame_num == uai_pkg::FRAME_RST))
      else $error("frame number not cleared");

   sof_frame_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_13
      (ce && !frame_capture_timing_select && sof.valid) |=> (frame_num == $past(sof.frame)))
      else $error("frame not taken on sof");

   iso_frame_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_14
      (ce && frame_capture_timing_select && sof.valid && !ev.trans_end) |=> $stable(frame_num))
      else $error("frame moved on sof in transaction mode");

   iso_update_a: assert property (@(posedge clk_sys) disable iff (rst || sw_reset) // RULE_14
      (ce && frame_capture_timing_select && ev.trans_end && ev.iso)
      |=> (frame_num == $past(sof_last)))
      else $error("frame not taken at transaction end");

   rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
      (ce && bus.rd && (bus.addr == uai_pkg::OFS_ADDR)) |=> (rdata[15:7] == 9'h000))
      else $error("reserved address bits nonzero");

   rsvd_iso_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
      (ce && bus.rd && (bus.addr == uai_pkg::OFS_ISO)) |=> (rdata[13:12] == 2'b00))
      else $error("reserved status bits nonzero");

   read_once_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && !bus.rd) |=> (rdata == uai_pkg::DATA_ZERO))
      else $error("read data outside read cycle");

   // =====================================================
   // Covers
   underrun_c: cover property (@(posedge clk_sys) disable iff (rst) underrun_in);
   frame_iso_c: cover property (@(posedge clk_sys) disable iff (rst)
      frame_capture_timing_select && ev.trans_end && ev.iso);
   crc_c: cover property (@(posedge clk_sys) disable iff (rst) rx_err_end);
   set_clr_c: cover property (@(posedge clk_sys) disable iff (rst) ovr_set && ovr_clr);
   sw_addr_c: cover property (@(posedge clk_sys) disable iff (rst)
      scs && wr_at(uai_pkg::OFS_ADDR));
endmodule // uai_usb_address_iso_status

// ---- verification/uai_host_model.sv ----
// =====================================================
// Far-side model: tokens, iso events and SOF packets
module uai_host_model (
   input  wire logic            clk_sys,
   output uai_pkg::uai_token_t  tok,
   output uai_pkg::uai_iso_t    ev,
   output uai_pkg::uai_sof_t    sof
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle lines at time zero
   initial begin
      tok = '0;
      ev  = '0;
      sof = '0;
   end

   // Token for one cycle, then fields scrambled
   task automatic send_token(input logic [6:0] a, input logic [3:0] e);
      @(posedge clk_sys);
      tok <= '{valid: 1'b1, addr: a, endp: e};
      @(posedge clk_sys);
      tok <= '{valid: 1'b0, addr: ~a, endp: ~e};
   endtask

   // Iso pulse: te 0 token end, 1 transaction end
   task automatic iso_event(input logic te, input logic [4:0] lv);
      @(posedge clk_sys);
      ev <= {~te, te, lv};
      @(posedge clk_sys);
      ev <= {2'b00, ~lv};
   endtask

   // Start of frame packet
   task automatic send_sof(input logic [10:0] f);
      @(posedge clk_sys);
      sof <= '{valid: 1'b1, frame: f};
      @(posedge clk_sys);
      sof <= '{valid: 1'b0, frame: ~f};
   endtask
endmodule // uai_host_model

// ---- verification/usb_address_iso_status_tb.sv ----
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end

// =====================================================
// Bench top
module usb_address_iso_status_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk_sys;
   logic                rst;
   logic                ce;
   logic                sw_reset;
   logic                bus_reset;
   uai_pkg::uai_bus_t   bus;
   logic [15:0]         rdata;
   logic                set_addr_valid;
   logic [6:0]          set_addr_value;
   uai_pkg::uai_token_t tok;
   uai_pkg::uai_iso_t   ev;
   uai_pkg::uai_sof_t   sof;
   logic [6:0]          dev_addr;
   logic                token_hit;
   logic [3:0]          token_endp;
   logic                nrdy_pulse;
   logic                irq;
   int                  n_fail;
   int                  check_count;
   int                  seed;
   int                  i;
   logic [6:0]          a;
   logic [6:0]          t;
   logic [3:0]          e;
   logic [10:0]         f;
   logic [10:0]         g;

   uai_usb_address_iso_status dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .sw_reset(sw_reset), .bus_reset(bus_reset), .bus(bus), .rdata(rdata),
      .set_addr_valid(set_addr_valid), .set_addr_value(set_addr_value), .tok(tok),
      .ev(ev), .sof(sof), .dev_addr(dev_addr), .token_hit(token_hit),
      .token_endp(token_endp), .nrdy_pulse(nrdy_pulse), .irq(irq));

   uai_host_model host (.clk_sys(clk_sys), .tok(tok), .ev(ev), .sof(sof));

   // Clock, 8 ns
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Expected status word
   function automatic logic [15:0] iso_exp(logic o, logic r, logic m, logic [10:0] fr);
      return {o, r, 2'b00, m, fr};
   endfunction

   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One-cycle register write
   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      @(posedge clk_sys);
      bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   // Read, data taken in the following cycle
   task automatic rchk(input string n, input logic [7:0] ad, input logic [15:0] x);
      @(posedge clk_sys);
      bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      `CHK(n, x, rdata)
   endtask

   // One-cycle pulse on a reset input
   task automatic pulse_rst(input logic sw);
      @(posedge clk_sys);
      if (sw) sw_reset <= 1'b1;
      else bus_reset <= 1'b1;
      @(posedge clk_sys);
      sw_reset <= 1'b0;
      bus_reset <= 1'b0;
   endtask

   // Hang guard
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      seed = 20253;
      rst = 1'b1;
      ce = 1'b1;
      sw_reset = 1'b0;
      bus_reset = 1'b0;
      bus = '0;
      set_addr_valid = 1'b0;
      set_addr_value = 7'h00;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rchk("addr_rst", uai_pkg::OFS_ADDR, 16'h0000);
      rchk("iso_rst", uai_pkg::OFS_ISO, 16'h0000);
      rchk("unmapped", 8'h02, 16'h0000);
      wr(uai_pkg::OFS_ADDR, 16'h0055);
      rchk("addr_nowr", uai_pkg::OFS_ADDR, 16'h0000);
      a = 7'($random(seed));
      @(posedge clk_sys);
      set_addr_valid <= 1'b1;
      set_addr_value <= a;
      @(posedge clk_sys);
      set_addr_valid <= 1'b0;
      set_addr_value <= ~a;
      rchk("addr_hw", uai_pkg::OFS_ADDR, {9'h000, a});
      `CHK("dev_addr", 16'(a), 16'(dev_addr))
      // Random tokens, about half aimed here
      for (i = 0; i < 20; i++) begin
         t = ($random(seed) & 1) ? a : 7'($random(seed));
         e = 4'($random(seed));
         host.send_token(t, e);
         #1;
         `CHK("token_hit", 16'(t == a), 16'(token_hit))
         if (t == a) `CHK("token_endp", 16'(e), 16'(token_endp))
      end
      // Software control mode, then both resets
      wr(uai_pkg::OFS_CTRL, 16'h0002);
      wr(uai_pkg::OFS_ADDR, 16'hffff);
      rchk("addr_sw", uai_pkg::OFS_ADDR, 16'h007f);
      pulse_rst(1'b0);
      rchk("addr_busrst", uai_pkg::OFS_ADDR, 16'h0000);
      rchk("ctrl_sel", uai_pkg::OFS_CTRL, 16'h0002);
      wr(uai_pkg::OFS_ADDR, 16'h0011);
      pulse_rst(1'b1);
      rchk("addr_swrst", uai_pkg::OFS_ADDR, 16'h0000);
      wr(uai_pkg::OFS_ADDR, 16'h0022);
      rchk("sel_swrst", uai_pkg::OFS_ADDR, 16'h0000);
      // Overrun and underrun at token end, both directions
      wr(uai_pkg::OFS_INT_MASK, 16'h0001);
      host.iso_event(1'b0, 5'b11000);
      rchk("no_ovr", uai_pkg::OFS_ISO, 16'h0000);
      for (i = 0; i < 2; i++) begin
         host.iso_event(1'b0, {1'b1, i[0], 3'b100});
         #1;
         `CHK("nrdy", 16'h0001, 16'(nrdy_pulse))
         @(posedge clk_sys);
         #1;
         `CHK("irq_on", 16'h0001, 16'(irq))
         rchk("ovr_set", uai_pkg::OFS_ISO, 16'h8000);
         wr(uai_pkg::OFS_ISO, 16'h8000);
         rchk("ovr_keep", uai_pkg::OFS_ISO, 16'h8000);
         wr(uai_pkg::OFS_ISO, 16'h0000);
         wr(uai_pkg::OFS_INT_STAT, 16'h0001);
         rchk("ovr_clr", uai_pkg::OFS_ISO, 16'h0000);
         `CHK("irq_off", 16'h0000, 16'(irq))
      end
      // CRC and stuffing errors on OUT data
      for (i = 0; i < 2; i++) begin
         host.iso_event(1'b1, {3'b110, i == 0, i == 1});
         rchk("rx_err", uai_pkg::OFS_ISO, 16'hc000);
         wr(uai_pkg::OFS_ISO, 16'h0000);
      end
      // Frame number capture in both timings
      f = 11'($random(seed));
      host.send_sof(f);
      rchk("frame_sof", uai_pkg::OFS_ISO, iso_exp(1'b0, 1'b0, 1'b0, f));
      rchk("int_stat", uai_pkg::OFS_INT_STAT, 16'h0003);
      rchk("int_mask", uai_pkg::OFS_INT_MASK, 16'h0001);
      wr(uai_pkg::OFS_ISO, 16'h3800);
      g = 11'($random(seed));
      host.send_sof(g);
      rchk("frame_hold", uai_pkg::OFS_ISO, iso_exp(1'b0, 1'b0, 1'b1, f));
      host.iso_event(1'b1, 5'b11000);
      rchk("frame_iso", uai_pkg::OFS_ISO, iso_exp(1'b0, 1'b0, 1'b1, g));
      // Clock enable low: SOF, transaction end and write all ignored
      @(posedge clk_sys);
      ce <= 1'b0;
      host.send_sof(~g);
      host.iso_event(1'b1, 5'b11000);
      wr(uai_pkg::OFS_ISO, 16'h0000);
      @(posedge clk_sys);
      ce <= 1'b1;
      rchk("frame_ce", uai_pkg::OFS_ISO, iso_exp(1'b0, 1'b0, 1'b1, g));
      report_and_stop();
   end
endmodule // usb_address_iso_status_tb
